// ===== rtl/sgcr_pkg.sv
// sgcr_pkg: constants and carrier types of the global control register bank
package sgcr_pkg;

    // ****************************************************************
    // register map and field positions
    // ****************************************************************
    localparam logic [7:0] ADDR_FAMILY   = 8'h00;
    localparam logic [7:0] ADDR_PART_RUN = 8'h01;
    localparam logic [7:0] ADDR_GCTL0    = 8'h02;
    localparam logic [7:0] ADDR_GCTL1    = 8'h03;

    localparam int BIT_RUN       = 0;
    localparam int BIT_BACKOFF   = 7;
    localparam int BIT_SOFT_RST  = 6;
    localparam int BIT_FLUSH_DYN = 5;
    localparam int BIT_FLUSH_STA = 4;
    localparam int BIT_INTEROP   = 1;
    localparam int BIT_LINK_AGE  = 0;

    // reset values and read-only reserved patterns
    localparam logic       RST_RUN       = 1'b1;
    localparam logic [7:0] GCTL0_RSV_ONE = 8'h0C;
    localparam logic [7:0] GCTL1_VALUE   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // identification values, arbitrary neutral codes
    localparam logic [7:0] FAMILY_IDENTIFIER_VAL = 8'h5A;
    localparam logic [3:0] PART_ID_VAL   = 4'h3;
    localparam logic [2:0] REVISION_VAL  = 3'h1;

    // ****************************************************************
    // serial port commands and framing
    // ****************************************************************
    localparam logic [7:0] CMD_WRITE   = 8'h02;
    localparam logic [7:0] CMD_READ    = 8'h03;
    localparam logic [2:0] BYTE_LAST   = 3'h7;

    // ****************************************************************
    // frame filter constants
    // ****************************************************************
    localparam logic [15:0] ETYPE_MAC_CTRL = 16'h8808;
    localparam logic [47:0] DA_PAUSE       = 48'h0180C2000001;
    localparam int          DA_GROUP_BIT   = 40;
    localparam int          NUM_PORTS      = 5;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam longint CLK_HZ         = 10000000;
    localparam longint FAST_AGE_US    = 800;
    localparam longint AGE_NORMAL_S   = 300;
    // 7999 cycles, one short of 800 us; with the >= compare fast aging still lasts the full 800 us
    localparam longint FAST_AGE_CYC   = FAST_AGE_US * CLK_HZ / 1000000 - 1;
    localparam longint AGE_NORMAL_CYC = AGE_NORMAL_S * CLK_HZ;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        SGCR_IDLE = 2'b00,
        SGCR_CMD  = 2'b01,
        SGCR_ADDR = 2'b11,
        SGCR_DATA = 2'b10
    } sgcr_spi_state_type;

    typedef struct packed {
        logic        valid;
        logic [47:0] da;
        logic [15:0] ethertype;
        logic        is_flow_ctrl;
    } sgcr_frame_hdr_type;

    typedef struct packed {
        logic                 valid;
        logic [NUM_PORTS-1:0] fwd_ports;
        logic [47:0]          mac;
    } sgcr_static_entry_type;

    typedef struct packed {
        logic       valid;
        logic [2:0] port;
    } sgcr_dyn_entry_type;

endpackage

// ===== rtl/sgcr_top.sv
// sgcr_top: global identification and control registers behind the spi port
`timescale 1ns/1ps
module sgcr_top #(
    parameter logic [31:0] FAST_AGE_CYC   = 32'(sgcr_pkg::FAST_AGE_CYC),
    parameter logic [31:0] AGE_NORMAL_CYC = 32'(sgcr_pkg::AGE_NORMAL_CYC)
) (
    input  wire logic                            clock,
    input  wire logic                            resetn,
    input  wire logic                            spi_sclk,
    input  wire logic                            spi_cs_n,
    input  wire logic                            spi_mosi,
    output logic                                 spi_miso,
    output logic                                 spi_miso_oe,
    input  wire sgcr_pkg::sgcr_frame_hdr_type    frame_hdr,
    output logic                                 frame_drop,
    output logic                                 frame_drop_valid,
    input  wire logic [sgcr_pkg::NUM_PORTS-1:0]  link_up,
    input  wire logic [sgcr_pkg::NUM_PORTS-1:0]  learn_disable,
    input  wire sgcr_pkg::sgcr_static_entry_type static_entry,
    input  wire sgcr_pkg::sgcr_dyn_entry_type    dyn_entry,
    input  wire logic                            flush_dyn_done,
    input  wire logic                            flush_sta_done,
    output logic                                 static_entry_remove,
    output logic                                 dyn_entry_remove,
    output logic                                 flush_dyn_start,
    output logic                                 flush_sta_start,
    output logic                                 switch_run,
    output logic                                 datapath_reset,
    output logic                                 rx_accept,
    output logic                                 backoff_alt,
    output logic                                 fast_age,
    output logic                                 age_tick
);

    // ****************************************************************
    // serial port: synchronisers and edge detection
    // ****************************************************************
    logic [2:0] sclk_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] mosi_sync_r;

    // two flops per pin, a third sclk stage for edges
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_sync_r <= 3'h0;
            cs_sync_r   <= 2'h3;
            mosi_sync_r <= 2'h0;
        end
        else
        begin
            sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
            cs_sync_r   <= {cs_sync_r[0], spi_cs_n};
            mosi_sync_r <= {mosi_sync_r[0], spi_mosi};
        end
    end

    wire sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
    wire sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
    wire selected  = ~cs_sync_r[1];
    wire mosi_bit  = mosi_sync_r[1];

    // ****************************************************************
    // serial port: command, address and data framing
    // ****************************************************************
    sgcr_pkg::sgcr_spi_state_type state_r, state_nxt;
    logic [2:0] bit_cnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] cmd_r;
    logic [7:0] addr_r;
    logic [7:0] tx_sh_r;
    logic [7:0] read_data;

    wire [7:0] rx_byte   = {rx_sh_r[6:0], mosi_bit};
    wire       byte_done = sclk_rise && (bit_cnt_r == sgcr_pkg::BYTE_LAST);
    wire       wr_en     = byte_done && (state_r == sgcr_pkg::SGCR_DATA)
                           && (cmd_r == sgcr_pkg::CMD_WRITE);
    wire [7:0] wr_data   = rx_byte;

    // next byte phase
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            sgcr_pkg::SGCR_IDLE: state_nxt = sgcr_pkg::SGCR_CMD;
            sgcr_pkg::SGCR_CMD:  state_nxt = sgcr_pkg::SGCR_ADDR;
            sgcr_pkg::SGCR_ADDR: state_nxt = sgcr_pkg::SGCR_DATA;
            sgcr_pkg::SGCR_DATA: state_nxt = sgcr_pkg::SGCR_DATA;
            default:             state_nxt = sgcr_pkg::SGCR_IDLE;
        endcase
    end

    // framing state, returns to idle whenever chip select drops
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r   <= sgcr_pkg::SGCR_IDLE;
            bit_cnt_r <= 3'h0;
            rx_sh_r   <= 8'h00;
        end
        else if (!selected)
        begin
            state_r   <= sgcr_pkg::SGCR_IDLE;
            bit_cnt_r <= 3'h0;
        end
        else
        begin
            if (state_r == sgcr_pkg::SGCR_IDLE)
                state_r <= sgcr_pkg::SGCR_CMD;
            else if (byte_done)
                state_r <= state_nxt;
            if (sclk_rise)
            begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                rx_sh_r   <= rx_byte;
            end
        end
    end

    // capture command and address bytes
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_r  <= 8'h00;
            addr_r <= 8'h00;
        end
        else if (byte_done && state_r == sgcr_pkg::SGCR_CMD)
            cmd_r <= rx_byte;
        else if (byte_done && state_r == sgcr_pkg::SGCR_ADDR)
            addr_r <= rx_byte;
    end

    // read data shifts out msb first on falling clock edges
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_sh_r     <= 8'h00;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            spi_miso_oe <= selected && (state_r == sgcr_pkg::SGCR_DATA)
                           && (cmd_r == sgcr_pkg::CMD_READ);
            if (byte_done && state_r == sgcr_pkg::SGCR_ADDR)
                tx_sh_r <= read_data;
            else if (sclk_fall && state_r == sgcr_pkg::SGCR_DATA)
            begin
                spi_miso <= tx_sh_r[7];
                tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic run_r, backoff_r, soft_rst_r, flush_dyn_r, flush_sta_r;
    logic interop_r, link_age_r;

    wire wr_part = wr_en && (addr_r == sgcr_pkg::ADDR_PART_RUN);
    wire wr_gc0  = wr_en && (addr_r == sgcr_pkg::ADDR_GCTL0);
    wire set_dyn = wr_gc0 && wr_data[sgcr_pkg::BIT_FLUSH_DYN];
    wire set_sta = wr_gc0 && wr_data[sgcr_pkg::BIT_FLUSH_STA];

    // writable bits; configuration ignores the soft reset
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            run_r      <= sgcr_pkg::RST_RUN;
            backoff_r  <= 1'b0;
            soft_rst_r <= 1'b0;
            interop_r  <= 1'b0;
            link_age_r <= 1'b0;
        end
        else
        begin
            if (wr_part)
                run_r <= wr_data[sgcr_pkg::BIT_RUN];
            if (wr_gc0)
            begin
                backoff_r  <= wr_data[sgcr_pkg::BIT_BACKOFF];
                soft_rst_r <= wr_data[sgcr_pkg::BIT_SOFT_RST];
                interop_r  <= wr_data[sgcr_pkg::BIT_INTEROP];
                link_age_r <= wr_data[sgcr_pkg::BIT_LINK_AGE];
            end
        end
    end

    // self-clearing flush bits, a new write wins over completion
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            flush_dyn_r     <= 1'b0;
            flush_sta_r     <= 1'b0;
            flush_dyn_start <= 1'b0;
            flush_sta_start <= 1'b0;
        end
        else
        begin
            flush_dyn_start <= set_dyn && !flush_dyn_r;
            flush_sta_start <= set_sta && !flush_sta_r;
            if (set_dyn)
                flush_dyn_r <= 1'b1;
            else if (flush_dyn_done)
                flush_dyn_r <= 1'b0;
            if (set_sta)
                flush_sta_r <= 1'b1;
            else if (flush_sta_done)
                flush_sta_r <= 1'b0;
        end
    end

    // read multiplexer with fixed identification and reserved bits;
    // keyed by the address byte as it completes, since addr_r lags a clock
    wire [7:0] rd_part = {sgcr_pkg::PART_ID_VAL, sgcr_pkg::REVISION_VAL,
                          run_r};
    wire [7:0] rd_gc0  = {backoff_r, soft_rst_r, flush_dyn_r, flush_sta_r,
                          2'b00, interop_r, link_age_r}
                         | sgcr_pkg::GCTL0_RSV_ONE;
    assign read_data =
        (rx_byte == sgcr_pkg::ADDR_FAMILY)   ? sgcr_pkg::FAMILY_IDENTIFIER_VAL :
        (rx_byte == sgcr_pkg::ADDR_PART_RUN) ? rd_part :
        (rx_byte == sgcr_pkg::ADDR_GCTL0)    ? rd_gc0 :
        (rx_byte == sgcr_pkg::ADDR_GCTL1)    ? sgcr_pkg::GCTL1_VALUE :
                                               sgcr_pkg::READ_UNMAPPED;

    // ****************************************************************
    // frame filter and flush qualification
    // ****************************************************************
    wire [sgcr_pkg::NUM_PORTS-1:0] fwd = static_entry.fwd_ports;
    wire single_port = (fwd != '0)
                       && ((fwd & (fwd - sgcr_pkg::NUM_PORTS'(1))) == '0);
    wire sta_match = static_entry.valid && flush_sta_r && single_port
                     && !static_entry.mac[sgcr_pkg::DA_GROUP_BIT]
                     && ((fwd & learn_disable) != '0);
    wire dyn_match = dyn_entry.valid && flush_dyn_r
                     && (dyn_entry.port < 3'(sgcr_pkg::NUM_PORTS))
                     && learn_disable[dyn_entry.port];
    wire drop_interop = (frame_hdr.ethertype == sgcr_pkg::ETYPE_MAC_CTRL)
                        || (frame_hdr.da == sgcr_pkg::DA_PAUSE);
    wire drop_sel = interop_r ? drop_interop
                              : frame_hdr.is_flow_ctrl;

    // registered filter and removal decisions; soft reset clears all but frame_drop
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            frame_drop          <= 1'b0;
            frame_drop_valid    <= 1'b0;
            static_entry_remove <= 1'b0;
            dyn_entry_remove    <= 1'b0;
        end
        else
        begin
            frame_drop_valid    <= frame_hdr.valid && !soft_rst_r;
            frame_drop          <= frame_hdr.valid && drop_sel;
            static_entry_remove <= sta_match && !soft_rst_r;
            dyn_entry_remove    <= dyn_match && !soft_rst_r;
        end
    end

    // ****************************************************************
    // aging timers and global run state
    // ****************************************************************
    logic [sgcr_pkg::NUM_PORTS-1:0] link_prev_r;
    logic [31:0]                    age_cnt_r;

    wire link_lost  = link_age_r && ((link_prev_r & ~link_up) != '0);
    wire age_expire = fast_age ? (age_cnt_r >= FAST_AGE_CYC)
                               : (age_cnt_r >= AGE_NORMAL_CYC - 32'h1);

    // one fast cycle ages out every entry, then the normal period resumes
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            link_prev_r <= '0;
            age_cnt_r   <= 32'h0;
            fast_age    <= 1'b0;
            age_tick    <= 1'b0;
        end
        else if (soft_rst_r)
        begin
            link_prev_r <= '0;
            age_cnt_r   <= 32'h0;
            fast_age    <= 1'b0;
            age_tick    <= 1'b0;
        end
        else
        begin
            link_prev_r <= link_up;
            age_tick    <= age_expire;
            if (link_lost)
            begin
                fast_age  <= 1'b1;
                age_cnt_r <= 32'h0;
            end
            else if (age_expire)
            begin
                fast_age  <= 1'b0;
                age_cnt_r <= 32'h0;
            end
            else
                age_cnt_r <= age_cnt_r + 32'h1;
        end
    end

    // run, back-off choice and datapath reset outputs
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            switch_run     <= 1'b0;
            datapath_reset <= 1'b0;
            rx_accept      <= 1'b0;
            backoff_alt    <= 1'b0;
        end
        else
        begin
            switch_run     <= run_r && !soft_rst_r;
            datapath_reset <= soft_rst_r;
            rx_accept      <= run_r && !soft_rst_r;
            backoff_alt    <= backoff_r;
        end
    end

endmodule

// ===== verification/sgcr_top_sva.sv
// sgcr_top_sva: concurrent checks on the register bank ports
`timescale 1ns/1ps
module sgcr_top_sva #(
    parameter logic [31:0] FAST_AGE_CYC   = 32'h14,
    parameter logic [31:0] AGE_NORMAL_CYC = 32'h32
) (
    input wire logic                            clock,
    input wire logic                            resetn,
    input wire sgcr_pkg::sgcr_frame_hdr_type    frame_hdr,
    input wire logic                            frame_drop_valid,
    input wire logic [sgcr_pkg::NUM_PORTS-1:0]  link_up,
    input wire logic [sgcr_pkg::NUM_PORTS-1:0]  learn_disable,
    input wire sgcr_pkg::sgcr_static_entry_type static_entry,
    input wire sgcr_pkg::sgcr_dyn_entry_type    dyn_entry,
    input wire logic                            static_entry_remove,
    input wire logic                            dyn_entry_remove,
    input wire logic                            flush_dyn_start,
    input wire logic                            flush_sta_start,
    input wire logic                            switch_run,
    input wire logic                            datapath_reset,
    input wire logic                            rx_accept,
    input wire logic                            fast_age,
    input wire logic                            age_tick
);
    // ****************************************************************
    // helper logic
    // ****************************************************************
    logic [4:0]  link_q;
    logic [31:0] fast_cnt;
    // a port lost its link this cycle
    wire lost = |(link_q & ~link_up);
    // entries that a flush may remove
    wire sta_ok = static_entry.valid && $onehot(static_entry.fwd_ports)
        && !static_entry.mac[sgcr_pkg::DA_GROUP_BIT]
        && |(static_entry.fwd_ports & learn_disable);
    wire dyn_ok = dyn_entry.valid && dyn_entry.port < 3'h5
        && learn_disable[dyn_entry.port];

    // previous link levels and length of the fast aging run
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            link_q   <= '1;
            fast_cnt <= '0;
        end
        else
        begin
            link_q   <= link_up;
            fast_cnt <= fast_age ? fast_cnt + 32'h1 : 32'h0;
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_fast_rise;
        !fast_age ##1 fast_age;
    endsequence
    property p_drop_valid; frame_drop_valid |-> $past(frame_hdr.valid);
    endproperty
    property p_drop_sr; datapath_reset [*2] |-> !frame_drop_valid; endproperty
    property p_rx; rx_accept |-> switch_run && !datapath_reset; endproperty
    property p_sr_halt; datapath_reset |-> !switch_run; endproperty
    property p_dyn_start; flush_dyn_start |=> !flush_dyn_start; endproperty
    property p_sta_start; flush_sta_start |=> !flush_sta_start; endproperty
    property p_dyn_rm; dyn_entry_remove |-> $past(dyn_ok); endproperty
    property p_sta_rm; static_entry_remove |-> $past(sta_ok); endproperty
    property p_fast_len; fast_cnt <= FAST_AGE_CYC + 32'h2; endproperty
    property p_fast_cause; s_fast_rise |-> $past(lost); endproperty
    property p_tick; age_tick |=> !age_tick; endproperty

    a_drop_valid: assert property (p_drop_valid)
        else $error("drop answer without a header");
    a_drop_sr: assert property (p_drop_sr)
        else $error("frame judged during soft reset");
    a_rx: assert property (p_rx)
        else $error("receive accepted while halted");
    a_sr_halt: assert property (p_sr_halt)
        else $error("switch runs during soft reset");
    a_dyn_start: assert property (p_dyn_start)
        else $error("dynamic flush start too long");
    a_sta_start: assert property (p_sta_start)
        else $error("static flush start too long");
    a_dyn_rm: assert property (p_dyn_rm)
        else $error("dynamic entry wrongly removed");
    a_sta_rm: assert property (p_sta_rm)
        else $error("static entry wrongly removed");
    a_fast_len: assert property (p_fast_len)
        else $error("fast aging runs too long");
    a_fast_cause: assert property (p_fast_cause)
        else $error("fast aging without link loss");
    a_tick: assert property (p_tick)
        else $error("age tick longer than a cycle");
endmodule

bind sgcr_top sgcr_top_sva #(
    .FAST_AGE_CYC   (FAST_AGE_CYC),
    .AGE_NORMAL_CYC (AGE_NORMAL_CYC)
) u_sva (
    .clock, .resetn, .frame_hdr, .frame_drop_valid, .link_up,
    .learn_disable, .static_entry, .dyn_entry, .static_entry_remove,
    .dyn_entry_remove, .flush_dyn_start, .flush_sta_start, .switch_run,
    .datapath_reset, .rx_accept, .fast_age, .age_tick
);

// ===== verification/sgcr_top_tb.sv
// sgcr_top_tb: self-checking bench for the global control register bank
`timescale 1ns/1ps
module sgcr_top_tb;
    localparam logic [31:0] FAST = 32'h14;
    localparam logic [31:0] NORM = 32'h32;
    logic clock, resetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic frame_drop, frame_drop_valid, static_entry_remove, dyn_entry_remove;
    logic flush_dyn_start, flush_sta_start, switch_run, datapath_reset;
    logic rx_accept, backoff_alt, fast_age, age_tick;
    logic flush_dyn_done, flush_sta_done, run_m, exp, oe;
    logic [4:0] link_up, learn_disable;
    logic [7:0] gc0_m, rd;
    sgcr_pkg::sgcr_frame_hdr_type    frame_hdr;
    sgcr_pkg::sgcr_static_entry_type static_entry;
    sgcr_pkg::sgcr_dyn_entry_type    dyn_entry;
    int err_count, comparisons, dyn_starts, sta_starts, i, k, n;

    sgcr_top #(.FAST_AGE_CYC(FAST), .AGE_NORMAL_CYC(NORM)) DUT (
        .clock, .resetn, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
        .spi_miso_oe, .frame_hdr, .frame_drop, .frame_drop_valid, .link_up,
        .learn_disable, .static_entry, .dyn_entry, .flush_dyn_done,
        .flush_sta_done, .static_entry_remove, .dyn_entry_remove,
        .flush_dyn_start, .flush_sta_start, .switch_run, .datapath_reset,
        .rx_accept, .backoff_alt, .fast_age, .age_tick);

    // clock and flush start counters, sampled away from the launching edge
    always #50 clock = ~clock;
    always @(negedge clock)
    begin
        dyn_starts += (flush_dyn_start === 1'b1);
        sta_starts += (flush_sta_start === 1'b1);
    end

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want)
        begin
            err_count++;
            $display("Error %0t: value %h expected %h", $time, got, want);
        end
    endtask
    task automatic chk_bit(input logic got, input logic want);
        comparisons++;
        if (got !== want)
        begin
            err_count++;
            $display("Error %0t: flag %b expected %b", $time, got, want);
        end
    endtask
    task automatic close_out;
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic clks(input int c);
        repeat (c) @(negedge clock);
    endtask
    // one 24-bit frame, sclk halves of 6 clocks
    task automatic spi(input logic [7:0] cmd, a, d);
        logic [23:0] f;
        f = {cmd, a, d};
        spi_cs_n = 1'b0;
        clks(4);
        for (int b = 23; b >= 0; b--)
        begin
            spi_mosi = f[b];
            clks(6);
            if (b < 8) rd[b] = spi_miso;
            if (b == 0) oe = spi_miso_oe;
            spi_sclk = 1'b1;
            clks(6);
            spi_sclk = 1'b0;
        end
        spi_cs_n = 1'b1;
        clks(4);
    endtask
    // write and track the expected register contents
    task automatic wr(input logic [7:0] a, d);
        spi(sgcr_pkg::CMD_WRITE, a, d);
        chk_bit(oe, 1'b0);
        if (a == 8'h01) run_m = d[0];
        if (a == 8'h02) gc0_m = (d & 8'hF3) | 8'h0C | (gc0_m & 8'h30);
    endtask
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h00: return sgcr_pkg::FAMILY_IDENTIFIER_VAL;
            8'h01: return {sgcr_pkg::PART_ID_VAL, sgcr_pkg::REVISION_VAL, run_m};
            8'h02: return gc0_m;
            default: return 8'h00;
        endcase
    endfunction
    task automatic rd_chk(input logic [7:0] a);
        spi(sgcr_pkg::CMD_READ, a, 8'h00);
        chk_bit(oe, 1'b1);
        chk_reg(rd, exp_rd(a));
    endtask
    task automatic wait_tick(output int c);
        c = 0;
        do
        begin
            clks(1);
            c++;
        end while (age_tick !== 1'b1 && c < 200);
        if (c >= 200)
        begin
            err_count++;
            $display("Error %0t: no age tick", $time);
            close_out();
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h462713C1));
        {clock, resetn, spi_sclk, spi_mosi, flush_dyn_done} = '0;
        {flush_sta_done, err_count, comparisons, dyn_starts, sta_starts} = '0;
        {frame_hdr, static_entry, dyn_entry, learn_disable} = '0;
        spi_cs_n = 1'b1;
        link_up = '1;
        run_m = 1'b1;
        gc0_m = 8'h0C;
        clks(2);
        resetn = 1'b1;
        clks(2);
        chk_bit(switch_run, 1'b1);
        for (i = 0; i < 5; i++) rd_chk((i == 4) ? 8'h7F : 8'(i));
        // random control writes, read-only places too
        for (i = 0; i < 6; i++)
        begin
            n = $urandom;
            wr(8'h01, n[7:0]);
            wr(8'h02, n[15:8] & 8'hCF);
            wr(i[0] ? 8'h00 : 8'h03, n[23:16]);
            for (k = 0; k < 4; k++) rd_chk(8'(k));
            chk_bit(switch_run, run_m & ~gc0_m[6]);
            chk_bit(datapath_reset, gc0_m[6]);
            chk_bit(rx_accept, run_m & ~gc0_m[6]);
            chk_bit(backoff_alt, gc0_m[7]);
        end
        // frame filter in both modes and under soft reset, back to back
        for (i = 0; i < 3; i++)
        begin
            wr(8'h02, (i == 0) ? 8'h00 : ((i == 1) ? 8'h02 : 8'h42));
            for (k = 0; k < 8; k++)
            begin
                frame_hdr.valid = 1'b1;
                frame_hdr.da = {16'h0000, 32'($urandom)};
                frame_hdr.ethertype = 16'($urandom);
                frame_hdr.is_flow_ctrl = k[1];
                if (k % 4 == 0) frame_hdr.ethertype = sgcr_pkg::ETYPE_MAC_CTRL;
                if (k % 4 == 1) frame_hdr.da = sgcr_pkg::DA_PAUSE;
                exp = gc0_m[1] ? (frame_hdr.ethertype == 16'h8808
                    || frame_hdr.da == 48'h0180C2000001) : k[1];
                clks(1);
                chk_bit(frame_drop_valid, ~gc0_m[6]);
                if (!gc0_m[6]) chk_bit(frame_drop, exp);
            end
            frame_hdr.valid = 1'b0;
        end
        // both flushes, entries offered while pending
        learn_disable = 5'($urandom);
        wr(8'h02, 8'h30);
        gc0_m = 8'h3C;
        for (k = 0; k < 24; k++)
        begin
            n = $urandom;
            static_entry.valid = 1'b1;
            static_entry.fwd_ports = k[0] ? 5'(1 << (k % 5)) : n[4:0];
            static_entry.mac = {7'h00, k[1], 8'h00, n};
            dyn_entry = {1'b1, n[7:5]};
            if (k == 12) learn_disable = 5'($urandom);
            clks(1);
            exp = $onehot(static_entry.fwd_ports) && !k[1]
                && |(static_entry.fwd_ports & learn_disable);
            chk_bit(static_entry_remove, exp);
            exp = n[7:5] < 3'h5 && learn_disable[n[7:5]];
            chk_bit(dyn_entry_remove, exp);
        end
        {static_entry, dyn_entry} = '0;
        wr(8'h02, 8'h30);
        chk_bit(dyn_starts == 1 && sta_starts == 1, 1'b1);
        rd_chk(8'h02);
        flush_dyn_done = 1'b1;
        clks(1);
        flush_dyn_done = 1'b0;
        gc0_m = 8'h1C;
        rd_chk(8'h02);
        flush_sta_done = 1'b1;
        clks(1);
        flush_sta_done = 1'b0;
        gc0_m = 8'h0C;
        rd_chk(8'h02);
        // link loss without and with link-change aging
        link_up[0] = 1'b0;
        clks(3);
        chk_bit(fast_age, 1'b0);
        wr(8'h02, 8'h01);
        link_up[2] = 1'b0;
        clks(2);
        chk_bit(fast_age, 1'b1);
        wait_tick(n);
        chk_bit(n <= FAST + 2, 1'b1);
        clks(2);
        chk_bit(fast_age, 1'b0);
        wait_tick(n);
        wait_tick(n);
        chk_reg(8'(n), 8'(NORM));
        close_out();
    end
endmodule
